// File: rtl/rcal_top.sv
// Calendar registers of the real-time clock with Avalon-MM slave
// Functional notes
// - Weekday 3-bit code, Sunday 000, upper zero
// - Weekday reachable on both pages
// - Day BCD 1..31, top bits zero
// - Day reachable on both pages
// - Page 0 month location: BCD month
// - Page 1 month location: 12/24 format bit
// - Page 0 year location: BCD year 00..99
// - Year register decoded only on page 0
// - Page 1 year location: leap-cycle field
// - Leap field visible only on page 1
// - Hour field: PM flag or 24-hour BCD
`timescale 1ns/1ns
`default_nettype none
module rcal_top
  import rcal_pkg::*;
(
  input wire logic clk_i, // 100 MHz clock
  input wire logic rst_n_i, // Async reset, active low
  input wire logic [RCAL_AW-1:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte lanes
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall until answer
  input wire logic hour_tick_i, // Hour counter wrap pulse
  output logic [7:0] hr_reg_o, // Hour register view
  output logic hour_fmt24_o, // 24-hour mode flag
  output logic page_o // Current page select
);

  // Complete module state
  typedef struct packed {
    rcal_cal_s cal;
    logic page;
    logic run;
    rcal_bus_e bus;
    logic [31:0] rdata;
  } rcal_state_s;

  rcal_state_s st;
  rcal_state_s next_st;

  logic [7:0] dom_next;
  logic dom_wrap;
  logic [7:0] mth_next;
  logic mth_wrap;
  logic [7:0] yr_next;
  logic yr_wrap;
  logic [7:0] hr_next;
  logic hr_wrap;
  logic [7:0] dom_last;
  logic [7:0] hr_last;
  logic [7:0] hr_first;
  logic [7:0] hr_cur;
  logic day_tick;
  logic wr_lo;

  // Address selects
  logic sel_dow;
  logic sel_dom;
  logic sel_mth;
  logic sel_yr;
  logic sel_hr;
  logic sel_ctrl;

  // Transfer qualifiers
  logic req_take;
  logic rd_take;
  logic wr_take;

  // Field write enables and read word
  logic we_dow;
  logic we_dom;
  logic we_mth;
  logic we_fmt;
  logic we_yr;
  logic we_leap;
  logic we_hr;
  logic we_ctrl;
  logic [31:0] rd_word;

  // Month length in BCD, February from leap phase
  always_comb begin
    dom_last = {2'h0, RCAL_DOM_31};
    if (st.cal.mth == RCAL_MTH_FEB) begin
      if (st.cal.leap == RCAL_LEAP_YES) begin
        dom_last = {2'h0, RCAL_DOM_29};
      end else begin
        dom_last = {2'h0, RCAL_DOM_28};
      end
    end else if (st.cal.mth == RCAL_MTH_APR || st.cal.mth == RCAL_MTH_JUN ||
                 st.cal.mth == RCAL_MTH_SEP || st.cal.mth == RCAL_MTH_NOV) begin
      dom_last = {2'h0, RCAL_DOM_30};
    end
  end

  // Hour wrap limits depend on format
  always_comb begin
    hr_cur = {2'h0, st.cal.hr};
    if (st.cal.fmt24) begin
      hr_last = {2'h0, RCAL_HR_23};
      hr_first = {2'h0, RCAL_HR_ZERO};
    end else begin
      hr_cur[RCAL_PM_BIT] = 1'b0;
      hr_last = {2'h0, RCAL_HR_11};
      hr_first = {2'h0, RCAL_HR_ZERO};
    end
  end

  // Day, month, year, hour incrementers
  rcal_bcd_inc #(.W(8)) u_dom (
    .val_i({2'h0, st.cal.dom}),
    .last_i(dom_last),
    .first_i({2'h0, RCAL_DOM_FIRST}),
    .next_o(dom_next),
    .wrap_o(dom_wrap)
  );
  rcal_bcd_inc #(.W(8)) u_mth (
    .val_i({3'h0, st.cal.mth}),
    .last_i({3'h0, RCAL_MTH_DEC}),
    .first_i({3'h0, RCAL_MTH_JAN}),
    .next_o(mth_next),
    .wrap_o(mth_wrap)
  );
  rcal_bcd_inc #(.W(8)) u_yr (
    .val_i(st.cal.yr),
    .last_i(RCAL_YR_LAST),
    .first_i(RCAL_YR_ZERO),
    .next_o(yr_next),
    .wrap_o(yr_wrap)
  );
  rcal_bcd_inc #(.W(8)) u_hr (
    .val_i(hr_cur),
    .last_i(hr_last),
    .first_i(hr_first),
    .next_o(hr_next),
    .wrap_o(hr_wrap)
  );

  // Day rolls at midnight: 23 in 24-hour, PM 11 in 12-hour
  assign day_tick = st.run && hour_tick_i && hr_wrap &&
                    (st.cal.fmt24 || st.cal.hr[RCAL_PM_BIT]);
  assign wr_lo = avs_write && avs_byteenable[0];

  // Address decode of the register locations
  always_comb begin
    sel_dow = 1'b0;
    sel_dom = 1'b0;
    sel_mth = 1'b0;
    sel_yr = 1'b0;
    sel_hr = 1'b0;
    sel_ctrl = 1'b0;
    if (avs_address == RCAL_OFS_DOW) begin
      sel_dow = 1'b1;
    end else if (avs_address == RCAL_OFS_DOM) begin
      sel_dom = 1'b1;
    end else if (avs_address == RCAL_OFS_MTH) begin
      sel_mth = 1'b1;
    end else if (avs_address == RCAL_OFS_YR) begin
      sel_yr = 1'b1;
    end else if (avs_address == RCAL_OFS_HR) begin
      sel_hr = 1'b1;
    end else if (avs_address == RCAL_OFS_CTRL) begin
      sel_ctrl = 1'b1;
    end
  end

  // Request taken in idle, write lands on the answer edge
  assign req_take = (st.bus == RCAL_IDLE) && (avs_read || avs_write);
  assign rd_take = (st.bus == RCAL_IDLE) && avs_read;
  assign wr_take = (st.bus == RCAL_ACK) && wr_lo;

  // Per-field write enables; shared locations split by page
  assign we_dow = wr_take && sel_dow;
  assign we_dom = wr_take && sel_dom;
  assign we_mth = wr_take && sel_mth && !st.page;
  assign we_fmt = wr_take && sel_mth && st.page;
  assign we_yr = wr_take && sel_yr && !st.page;
  assign we_leap = wr_take && sel_yr && st.page;
  assign we_hr = wr_take && sel_hr;
  assign we_ctrl = wr_take && sel_ctrl;

  // Read mux of the addressed location, page picks shared views
  always_comb begin
    rd_word = 32'h0;
    if (sel_dow) begin
      rd_word = {29'h0, st.cal.dow};
    end else if (sel_dom) begin
      rd_word = {26'h0, st.cal.dom};
    end else if (sel_mth && st.page) begin
      rd_word = {31'h0, st.cal.fmt24};
    end else if (sel_mth) begin
      rd_word = {27'h0, st.cal.mth};
    end else if (sel_yr && st.page) begin
      rd_word = {30'h0, st.cal.leap};
    end else if (sel_yr) begin
      rd_word = {24'h0, st.cal.yr};
    end else if (sel_hr) begin
      rd_word = {26'h0, st.cal.hr};
    end else if (sel_ctrl) begin
      rd_word = {30'h0, st.run, st.page};
    end else begin
      rd_word = 32'h0; // Unmapped locations read zero
    end
  end

  // Next-state logic: counting, register writes, bus answer
  always_comb begin
    next_st = st;
    // Hour and calendar advance
    if (st.run && hour_tick_i) begin
      next_st.cal.hr = hr_next[RCAL_HR_W-1:0];
      if (!st.cal.fmt24 && hr_wrap) begin
        next_st.cal.hr[RCAL_PM_BIT] = ~st.cal.hr[RCAL_PM_BIT];
      end else if (!st.cal.fmt24) begin
        next_st.cal.hr[RCAL_PM_BIT] = st.cal.hr[RCAL_PM_BIT];
      end
    end
    if (day_tick) begin
      if (st.cal.dow == RCAL_DOW_SAT) begin
        next_st.cal.dow = RCAL_DOW_SUN;
      end else begin
        next_st.cal.dow = st.cal.dow + 3'h1;
      end
      next_st.cal.dom = dom_next[RCAL_DOM_W-1:0];
      if (dom_wrap) begin
        next_st.cal.mth = mth_next[RCAL_MTH_W-1:0];
        if (mth_wrap) begin
          next_st.cal.yr = yr_next;
          next_st.cal.leap = st.cal.leap + RCAL_LEAP_ONE;
        end
      end
    end
    // Bus handshake: one wait cycle, then answer
    next_st.bus = RCAL_IDLE;
    if (req_take) begin
      next_st.bus = RCAL_ACK;
    end
    // Register writes take effect on the answer edge; writes win over counting
    if (we_dow) begin
      next_st.cal.dow = avs_writedata[RCAL_DOW_W-1:0];
    end
    if (we_dom) begin
      next_st.cal.dom = avs_writedata[RCAL_DOM_W-1:0];
    end
    if (we_mth) begin
      next_st.cal.mth = avs_writedata[RCAL_MTH_W-1:0];
    end
    if (we_fmt) begin
      next_st.cal.fmt24 = avs_writedata[0];
    end
    if (we_yr) begin
      next_st.cal.yr = avs_writedata[RCAL_YR_W-1:0];
    end
    if (we_leap) begin
      next_st.cal.leap = avs_writedata[RCAL_LEAP_W-1:0];
    end
    if (we_hr) begin
      next_st.cal.hr = avs_writedata[RCAL_HR_W-1:0];
    end
    if (we_ctrl) begin
      next_st.page = avs_writedata[RCAL_CTRL_PAGE];
      next_st.run = avs_writedata[RCAL_CTRL_RUN];
    end
    // Read data captured at request, shown at the answer edge
    next_st.rdata = 32'h0;
    if (rd_take) begin
      next_st.rdata = rd_word;
    end else if (st.bus == RCAL_ACK) begin
      next_st.rdata = st.rdata;
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st.cal.dow <= RCAL_DOW_SUN;
      st.cal.dom <= RCAL_DOM_FIRST;
      st.cal.mth <= RCAL_MTH_JAN;
      st.cal.yr <= RCAL_YR_ZERO;
      st.cal.leap <= RCAL_LEAP_YES;
      st.cal.hr <= RCAL_HR_ZERO;
      st.cal.fmt24 <= 1'b1;
      st.page <= 1'b0;
      st.run <= 1'b0;
      st.bus <= RCAL_IDLE;
      st.rdata <= 32'h0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs
  assign avs_waitrequest = (avs_read || avs_write) && (st.bus == RCAL_IDLE);
  assign avs_readdata = st.rdata;
  assign hr_reg_o = {2'h0, st.cal.hr};
  assign hour_fmt24_o = st.cal.fmt24;
  assign page_o = st.page;

endmodule
`default_nettype wire

// File: rtl/rcal_pkg.sv
// Package with register map, field layouts and types of the calendar block
package rcal_pkg;

  // Register word offsets (byte addresses, one aligned word each)
  localparam logic [4:0] RCAL_OFS_DOW = 5'h00;
  localparam logic [4:0] RCAL_OFS_DOM = 5'h04;
  localparam logic [4:0] RCAL_OFS_MTH = 5'h08;
  localparam logic [4:0] RCAL_OFS_YR = 5'h0c;
  localparam logic [4:0] RCAL_OFS_HR = 5'h10;
  localparam logic [4:0] RCAL_OFS_CTRL = 5'h14;
  localparam int RCAL_AW = 5;

  // Control register bit positions
  localparam int RCAL_CTRL_PAGE = 0;
  localparam int RCAL_CTRL_RUN = 1;

  // Field widths
  localparam int RCAL_DOW_W = 3;
  localparam int RCAL_DOM_W = 6;
  localparam int RCAL_MTH_W = 5;
  localparam int RCAL_YR_W = 8;
  localparam int RCAL_HR_W = 6;
  localparam int RCAL_LEAP_W = 2;

  // Encodings and reset values
  localparam logic [2:0] RCAL_DOW_SUN = 3'h0;
  localparam logic [2:0] RCAL_DOW_SAT = 3'h6;
  localparam logic [5:0] RCAL_DOM_FIRST = 6'h01;
  localparam logic [4:0] RCAL_MTH_JAN = 5'h01;
  localparam logic [4:0] RCAL_MTH_FEB = 5'h02;
  localparam logic [4:0] RCAL_MTH_APR = 5'h04;
  localparam logic [4:0] RCAL_MTH_JUN = 5'h06;
  localparam logic [4:0] RCAL_MTH_SEP = 5'h09;
  localparam logic [4:0] RCAL_MTH_NOV = 5'h11;
  localparam logic [4:0] RCAL_MTH_DEC = 5'h12;
  localparam logic [5:0] RCAL_DOM_28 = 6'h28;
  localparam logic [5:0] RCAL_DOM_29 = 6'h29;
  localparam logic [5:0] RCAL_DOM_30 = 6'h30;
  localparam logic [5:0] RCAL_DOM_31 = 6'h31;
  localparam logic [7:0] RCAL_YR_ZERO = 8'h00;
  localparam logic [7:0] RCAL_YR_LAST = 8'h99;
  localparam logic [1:0] RCAL_LEAP_YES = 2'h0;
  localparam logic [1:0] RCAL_LEAP_ONE = 2'h1;
  localparam logic [5:0] RCAL_HR_ZERO = 6'h00;
  localparam logic [5:0] RCAL_HR_23 = 6'h23;
  localparam logic [5:0] RCAL_HR_11 = 6'h11;
  localparam int RCAL_PM_BIT = 5;
  localparam logic [3:0] RCAL_BCD_NINE = 4'h9;
  localparam logic [3:0] RCAL_NIB_ONE = 4'h1;

  // Bus answer state
  typedef enum logic [1:0] {
    RCAL_IDLE = 2'b00,
    RCAL_ACK = 2'b01
  } rcal_bus_e;

  // Calendar state carried between processes
  typedef struct packed {
    logic [2:0] dow;
    logic [5:0] dom;
    logic [4:0] mth;
    logic [7:0] yr;
    logic [1:0] leap;
    logic [5:0] hr;
    logic fmt24;
  } rcal_cal_s;

endpackage

// File: rtl/rcal_bcd_inc.sv
// Two-digit BCD incrementer with wrap to a given start value
`timescale 1ns/1ns
`default_nettype none
module rcal_bcd_inc
  import rcal_pkg::*;
#(
  parameter int W = 8
) (
  input wire logic [W-1:0] val_i, // Current BCD value
  input wire logic [W-1:0] last_i, // Last legal value
  input wire logic [W-1:0] first_i, // Value after wrap
  output logic [W-1:0] next_o, // Incremented value
  output logic wrap_o // Wrapped to first
);

  // Units carry into tens, wrap at last value
  always_comb begin
    next_o = val_i;
    wrap_o = (val_i == last_i);
    if (wrap_o) begin
      next_o = first_i;
    end else if (val_i[3:0] == RCAL_BCD_NINE) begin
      next_o = val_i + W'(16'h0007);
    end else begin
      next_o = val_i + W'(16'h0001);
    end
  end
endmodule
`default_nettype wire

// File: verif/rcal_top_monitor.sv
// Bus timing and register view checker of the calendar block
`timescale 1ns/1ns
`default_nettype none
module rcal_top_monitor
  import rcal_pkg::*;
(
  input wire logic clk_i, // Clock
  input wire logic rst_n_i, // Reset
  input wire logic [RCAL_AW-1:0] avs_address, // Address
  input wire logic avs_read, // Read
  input wire logic avs_write, // Write
  input wire logic [31:0] avs_writedata, // Data in
  input wire logic [3:0] avs_byteenable, // Lanes
  input wire logic [31:0] avs_readdata, // Data out
  input wire logic avs_waitrequest, // Stall
  input wire logic hour_tick_i, // Hour tick
  input wire logic [7:0] hr_reg_o, // Hour view
  input wire logic hour_fmt24_o, // Format
  input wire logic page_o // Page
);
  logic req;
  logic rdok;
  logic [4:0] ad;
  // Request and read answer qualifiers
  assign req = avs_read | avs_write;
  assign rdok = avs_read & ~avs_waitrequest;
  assign ad = avs_address;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // Bus handshake and register views
  property p_wait1; avs_waitrequest |=> !avs_waitrequest; endproperty
  property p_req; $rose(req) |-> avs_waitrequest; endproperty
  property p_idle; !req |-> !avs_waitrequest; endproperty
  property p_dow; rdok && ad == RCAL_OFS_DOW |-> avs_readdata <= 32'h6; endproperty
  property p_dom;
    rdok && ad == RCAL_OFS_DOM |-> avs_readdata != 32'h0 && avs_readdata <= 32'h31
      && avs_readdata[3:0] <= 4'h9;
  endproperty
  property p_mth;
    rdok && ad == RCAL_OFS_MTH && !page_o |-> avs_readdata != 32'h0
      && avs_readdata <= 32'h12 && avs_readdata[3:0] <= 4'h9;
  endproperty
  property p_fmt;
    rdok && ad == RCAL_OFS_MTH && page_o |-> avs_readdata == {31'h0, hour_fmt24_o};
  endproperty
  property p_yr;
    rdok && ad == RCAL_OFS_YR && !page_o |-> avs_readdata[31:8] == 24'h0
      && avs_readdata[7:4] <= 4'h9 && avs_readdata[3:0] <= 4'h9;
  endproperty
  property p_leap; rdok && ad == RCAL_OFS_YR && page_o |-> avs_readdata[31:2] == 30'h0;
  endproperty
  property p_hr;
    $changed(hr_reg_o) |-> hr_reg_o[7:6] == 2'h0
      && (hour_fmt24_o ? hr_reg_o[5:0] <= 6'h23 : hr_reg_o[4:0] <= 5'h11);
  endproperty
  a_wait1: assert property (p_wait1) else $error("wait longer than one cycle");
  a_req: assert property (p_req) else $error("request not stalled");
  a_idle: assert property (p_idle) else $error("stall without request");
  a_dow: assert property (p_dow) else $error("weekday read bad");
  a_dom: assert property (p_dom) else $error("day read bad");
  a_mth: assert property (p_mth) else $error("month read bad");
  a_fmt: assert property (p_fmt) else $error("format read bad");
  a_yr: assert property (p_yr) else $error("year read bad");
  a_leap: assert property (p_leap) else $error("leap read bad");
  a_hr: assert property (p_hr) else $error("hour value bad");
  c_tick: cover property (hour_tick_i && hr_reg_o[5:0] == 6'h23);
  c_pg1: cover property (rdok && page_o);
  c_wr: cover property (avs_write && !avs_waitrequest);
endmodule
bind rcal_top rcal_top_monitor u_mon (.clk_i, .rst_n_i, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
  .hour_tick_i, .hr_reg_o, .hour_fmt24_o, .page_o);
`default_nettype wire

// File: verif/tb_rcal_top.sv
// Self-checking testbench of the calendar registers
`timescale 1ns/1ns
`default_nettype none
module tb_rcal_top
  import rcal_pkg::*;
;
  typedef struct packed {logic pg; logic [4:0] a; logic [31:0] d; logic [31:0] e;} rcal_row_s;
  localparam rcal_row_s ROWS [10] = '{
    '{1'h0, RCAL_OFS_DOW, 32'hf6, 32'h6}, '{1'h1, RCAL_OFS_DOW, 32'h1, 32'h1},
    '{1'h0, RCAL_OFS_DOM, 32'h31, 32'h31}, '{1'h1, RCAL_OFS_DOM, 32'h28, 32'h28},
    '{1'h0, RCAL_OFS_MTH, 32'h12, 32'h12}, '{1'h1, RCAL_OFS_MTH, 32'h0, 32'h0},
    '{1'h1, RCAL_OFS_MTH, 32'h1, 32'h1}, '{1'h0, RCAL_OFS_YR, 32'h99, 32'h99},
    '{1'h1, RCAL_OFS_YR, 32'h3, 32'h3}, '{1'h0, RCAL_OFS_YR, 32'h45, 32'h45}};
  logic clk_i;
  logic rst_n_i;
  logic [4:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic hour_tick_i;
  logic [7:0] hr_reg_o;
  logic hour_fmt24_o;
  logic page_o;
  logic [31:0] v;
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;
  // Clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  rcal_top dut (.clk_i, .rst_n_i, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .hour_tick_i, .hr_reg_o,
    .hour_fmt24_o, .page_o);
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One bus transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_i);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clk_i); while (avs_waitrequest !== 1'b0);
    v = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic rdc(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(v, e);
  endtask
  task automatic ctl(input logic pg, input logic run);
    bus(1'b1, RCAL_OFS_CTRL, {30'h0, run, pg});
  endtask
  // One hour tick with the clock running
  task automatic tk;
    ctl(1'b0, 1'b1);
    @(posedge clk_i);
    hour_tick_i <= 1'b1;
    @(posedge clk_i);
    hour_tick_i <= 1'b0;
    ctl(1'b0, 1'b0);
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      final_report;
    end
  end
  // Main sequence
  initial begin
    rst_n_i = 1'b0;
    avs_address = 5'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    hour_tick_i = 1'b0;
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    chk({22'h0, page_o, hour_fmt24_o, hr_reg_o}, 32'h100);
    rdc(RCAL_OFS_DOW, 32'h0);
    foreach (ROWS[i]) begin
      ctl(ROWS[i].pg, 1'b0);
      bus(1'b1, ROWS[i].a, ROWS[i].d);
      rdc(ROWS[i].a, ROWS[i].e);
    end
    // Shared year location and an unmapped place
    ctl(1'b1, 1'b0);
    rdc(RCAL_OFS_YR, 32'h3);
    ctl(1'b0, 1'b0);
    rdc(RCAL_OFS_YR, 32'h45);
    bus(1'b1, 5'h18, 32'hff);
    rdc(5'h18, 32'h0);
    // Write with lane 0 disabled is answered but ignored
    avs_byteenable <= 4'he;
    bus(1'b1, RCAL_OFS_DOW, 32'h5);
    avs_byteenable <= 4'hf;
    rdc(RCAL_OFS_DOW, 32'h1);
    // Year end rollover in 24-hour mode
    bus(1'b1, RCAL_OFS_DOW, 32'h6);
    bus(1'b1, RCAL_OFS_DOM, 32'h31);
    bus(1'b1, RCAL_OFS_YR, 32'h99);
    bus(1'b1, RCAL_OFS_HR, 32'h23);
    tk;
    rdc(RCAL_OFS_DOW, 32'h0);
    rdc(RCAL_OFS_DOM, 32'h1);
    rdc(RCAL_OFS_MTH, 32'h1);
    rdc(RCAL_OFS_YR, 32'h0);
    ctl(1'b1, 1'b0);
    rdc(RCAL_OFS_YR, 32'h0);
    // Leap February, then 12-hour wrap into March
    ctl(1'b0, 1'b0);
    bus(1'b1, RCAL_OFS_MTH, 32'h2);
    bus(1'b1, RCAL_OFS_DOM, 32'h28);
    bus(1'b1, RCAL_OFS_HR, 32'h23);
    tk;
    rdc(RCAL_OFS_DOM, 32'h29);
    ctl(1'b1, 1'b0);
    bus(1'b1, RCAL_OFS_MTH, 32'h0);
    ctl(1'b0, 1'b0);
    bus(1'b1, RCAL_OFS_HR, 32'h31);
    tk;
    chk({24'h0, hr_reg_o}, 32'h0);
    rdc(RCAL_OFS_MTH, 32'h3);
    rdc(RCAL_OFS_DOM, 32'h1);
    // Reset with page 1 and 12-hour mode set, clock stopped, brings back the defaults
    ctl(1'b1, 1'b0);
    chk({31'h0, hour_fmt24_o}, 32'h0);
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    chk({22'h0, page_o, hour_fmt24_o, hr_reg_o}, 32'h100);
    rdc(RCAL_OFS_DOW, 32'h0);
    final_report;
  end
endmodule
`default_nettype wire
